// ==== tb/bfx_exec_assertions.sv ====
// Checker for bfx_exec: bus handshake timing and retire-record relations.
// Bound to every bfx_exec instance; sees its ports only.
`timescale 1ns/100ps
module bfx_exec_assertions
  import bfx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire bfx_retire_t retire
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire logic req = avs_read | avs_write;
  wire logic start = avs_write & ~avs_waitrequest & avs_byteenable[0] & avs_writedata[BFX_CTRL_START]
    & (avs_address == ADDR_W'(BFX_OFF_CTRL));
  a_wait_idle: assert property (!req |-> !avs_waitrequest) else $error("waitrequest while idle");
  a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("extra wait state");
  a_wait_again: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest) else $error("no wait state");
  a_start_retire: assert property (start |-> ##2 retire.valid) else $error("retire late");
  a_valid_pulse: assert property (retire.valid |=> !retire.valid) else $error("valid too long");
  a_breakpoint_op_event: assert property (retire.breakpoint_op_monitor || retire.breakpoint_op_halt |-> retire.valid
    && !(retire.breakpoint_op_monitor && retire.breakpoint_op_halt) && !retire.wr_dest) else $error("bad breakpoint");
  a_unpred_quiet: assert property (retire.valid && retire.unpredictable |-> !(retire.wr_dest
    || retire.wr_flags || retire.wr_link || retire.branch)) else $error("unpredictable wrote");
  a_link_odd: assert property (retire.valid && retire.wr_link |-> retire.link_data[0] && retire.branch
    && retire.dest_num == BFX_REG_LINK) else $error("bad link write");
  a_dest_legal: assert property (retire.valid && retire.wr_dest |-> retire.dest_num != BFX_REG_SP
    && retire.dest_num != BFX_REG_PC) else $error("bad destination");
  a_flags_follow: assert property (retire.valid && retire.wr_flags |-> retire.wr_dest
    && retire.flags[BFX_FLAG_N] == retire.dest_data[31]
    && retire.flags[BFX_FLAG_Z] == (retire.dest_data == 32'h0)) else $error("bad flags");
endmodule
bind bfx_exec bfx_exec_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .retire(retire));

// ==== tb/testbench.sv ====
// Bench for bfx_exec: loads operands over the register bus, starts, checks each retire record.
// Assumes the executor's register map and its one-wait-state bus.
`timescale 1ns/100ps
module testbench;
  import bfx_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdv, rn, rm, rdo, pc, w, msk, ins;
  logic avs_waitrequest;
  logic [3:0] fl, d, n;
  logic [4:0] lo, hi, amt, c;
  bfx_retire_t retire, e, x;
  bfx_retire_t exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] bad[10] = '{32'hF36F_0D1F, 32'hF362_0F1F, 32'hF36D_011F, 32'hF36F_1142, 32'hF021_0D00,
    32'hF000_F800, 32'hF021_0200, 32'hF000_F800, 32'hF380_8000, 32'hF3C0_8000};
  always #25 clk = ~clk;
  bfx_exec #(.ADDR_W(8)) dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .retire(retire));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Request held until waitrequest is seen low at a rising edge; read data taken at that edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] dt);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= dt;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic exec(input logic [31:0] i, input logic [4:0] ct);
    bus(1'b1, BFX_OFF_INSTR, i);
    bus(1'b1, BFX_OFF_RN_VAL, rn);
    bus(1'b1, BFX_OFF_RM_VAL, rm);
    bus(1'b1, BFX_OFF_RD_VAL, rdo);
    bus(1'b1, BFX_OFF_PC_VAL, pc);
    bus(1'b1, BFX_OFF_FLAGS_IN, {28'h0, fl});
    exp_q.push_back(e);
    bus(1'b1, BFX_OFF_CTRL, {27'h0, ct | 5'h01});
  endtask
  function automatic bfx_retire_t rr(input logic [3:0] dn, input logic [31:0] r, input logic fs, input logic cy);
    return '{valid: 1'b1, wr_dest: 1'b1, dest_num: dn, dest_data: r, wr_flags: fs,
      flags: {r[31], r == 32'h0, cy, fl[0]}, default: 0};
  endfunction
  function automatic logic [31:0] key(input bfx_retire_t r);
    return {17'h0, r.unpredictable, r.wr_dest, r.wr_flags, r.wr_link, r.branch, r.breakpoint_op_monitor, r.breakpoint_op_halt,
      (r.wr_dest | r.wr_link) ? r.dest_num : 4'h0, r.wr_flags ? r.flags : 4'h0};
  endfunction
  always @(negedge clk) begin
    if (retire.valid === 1'b1) begin
      x = (exp_q.size() > 0) ? exp_q.pop_front() : bfx_retire_t'(0);
      check("kind", key(retire), key(x));
      if (x.wr_dest) check("dest", retire.dest_data, x.dest_data);
      if (x.wr_link) check("link", retire.link_data, x.link_data);
      if (x.wr_link) check("target", retire.target, x.target);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(51989));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h30, 32'h0);
    check("unmapped", rdv, 32'h0);
    bus(1'b0, BFX_OFF_RESULT, 32'h0);
    check("result", rdv, BFX_WORD_RST);
    for (int k = 0; k < 36; k++) begin
      rn = $urandom;
      rm = $urandom;
      rdo = $urandom;
      pc = $urandom & 32'hFFFF_FFFE;
      w = $urandom;
      fl = 4'($urandom);
      d = 4'($urandom % 13);
      n = 4'($urandom % 13);
      lo = (k < 2) ? 5'(k * 31) : 5'($urandom);
      hi = (k < 2) ? 5'h1F : 5'(lo + $urandom % (32 - lo));
      amt = 5'(1 + $urandom % 31);
      msk = (32'hFFFF_FFFF >> (5'h1F - hi)) & (32'hFFFF_FFFF << lo);
      c = (k % 12 == 4) ? 5'h06 : (k % 12 == 5) ? 5'h0E : 5'h02;
      case (k % 6)
        0: begin
          e = rr(d, rdo & ~msk, 1'b0, 1'b0);
          ins = {16'hF36F, 1'b0, lo[4:2], d, lo[1:0], 1'b0, hi};
        end
        1: begin
          e = rr(d, (rdo & ~msk) | ((rn << lo) & msk), 1'b0, 1'b0);
          ins = {12'hF36, n, 1'b0, lo[4:2], d, lo[1:0], 1'b0, hi};
        end
        2: begin
          e = rr(d, rn & ~{24'h0, w[7:0]}, w[8], fl[1]);
          ins = {11'b11110000001, w[8], n, 4'h0, d, w[7:0]};
        end
        3: begin
          e = rr(d, rn & ~(rm << amt), w[8], rm[32 - amt]);
          ins = {11'b11101010001, w[8], n, 1'b0, amt[4:2], d, amt[1:0], 2'b00, 1'b0, w[11:9]};
        end
        4: begin
          e = rr({1'b0, d[2:0]}, rn & ~rm, c != 5'h06, fl[1]);
          ins = {10'b0100001110, n[2:0], d[2:0], 16'h0};
        end
        default: begin
          e = '{valid: 1'b1, wr_link: 1'b1, dest_num: BFX_REG_LINK, link_data: pc | 32'h1, branch: 1'b1,
            target: pc + {{8{w[23]}}, ~(w[22] ^ w[23]), ~(w[21] ^ w[23]), w[20:0], 1'b0}, default: 0};
          ins = {5'b11110, w[23], w[20:11], 2'b11, w[22], 1'b1, w[21], w[10:0]};
        end
      endcase
      exec(ins, c);
    end
    for (int k = 0; k < 10; k++) begin
      e = '{valid: 1'b1, unpredictable: k < 6, default: 0};
      exec(bad[k], (k == 5) ? 5'h06 : (k == 6 || k == 7) ? 5'h00 : 5'h02);
      if (k > 5) begin
        bus(1'b0, BFX_OFF_STATUS, 32'h0);
        check("rsvd", 32'(rdv[BFX_ST_RSVD_COND]), 32'(k > 7));
      end
    end
    for (int h = 0; h < 2; h++) begin
      e = '{valid: 1'b1, breakpoint_op_monitor: h == 0, breakpoint_op_halt: h == 1, default: 0};
      exec({8'hBE, 8'($urandom), 16'h0}, (h == 1) ? 5'h14 : 5'h04);
    end
    repeat (4) @(posedge clk);
    check("pending", 32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule

// ==== verilog/bfx_exec.sv ====
// Executor for field clear/insert, bit clear, breakpoint and branch-with-link, with an Avalon-MM slave.
// Assumes software loads operands and condition context, then starts one instruction at a time.
// Notes on behaviour
// - Conditional-branch form with condition 1110 or 1111 is another instruction, not a branch.
// - Field clear zeroes destination bits low..high, other bits kept.
// - Field clear low from imm_three_bit_field:imm_two_bit_field, high from top field; destination 13/15 unpredictable.
// - Field clear and insert update only when high is not below low.
// - Field insert copies source low bits into destination low..high range.
// - Field insert with source field all ones decodes as field clear.
// - Field insert unpredictable for destination 13/15 or source 13.
// - Immediate bit clear writes first operand AND NOT expanded immediate.
// - Wide bit clear sets flags when S is one; destination/operand 13/15 unpredictable.
// - Flags: N from bit 31, Z on zero, C from expansion or shifter, V kept.
// - Narrow bit clear shares destination and operand, shift zero, flags outside block only.
// - Register bit clear ANDs first operand with complement of shifted second operand.
// - Data and branch operations act only when the condition check passes.
// - Breakpoint raises monitor exception or halt, chosen by debug configuration.
// - Breakpoint executes unconditionally, inside or outside a conditional block.
// - Breakpoint immediate byte is ignored by hardware.
// - Branch-with-link offset sign-extends S, two inverted J xor S bits, fields, zero.
// - Branch-with-link inside a block but not last is unpredictable.
// - Link gets next instruction address with bit 0 set; branch to PC plus offset.
`timescale 1ns/100ps
module bfx_exec
  import bfx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output bfx_retire_t retire
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("bfx_exec: ADDR_W must be at least 8");
  end

  typedef enum logic {BFX_ST_IDLE, BFX_ST_EXEC} bfx_state_t;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
    return r;
  endfunction

  // Returns {carry, result}
  function automatic logic [32:0] shift_c(input logic [31:0] v, input bfx_shift_t t, input logic [5:0] amt,
                                          input logic cin);
    logic [32:0] ext;
    logic [63:0] dbl;
    ext = {cin, v};
    dbl = {v, v} >> amt[4:0];
    if (amt == 6'h00 && t != BFX_SH_RRX) begin
      ext = {cin, v};
    end else begin
      case (t)
        BFX_SH_LSL: ext = {1'b0, v} << amt;
        BFX_SH_LSR: begin
          ext = {v, 1'b0} >> amt;
          ext = {ext[0], ext[32:1]};
        end
        BFX_SH_ASR: begin
          ext = 33'($signed({v, 1'b0}) >>> amt);
          ext = {ext[0], ext[32:1]};
        end
        BFX_SH_ROR: ext = {dbl[31], dbl[31:0]};
        default: ext = {v[0], cin, v[31:1]};
      endcase
    end
    return ext;
  endfunction

  // Returns {carry, unpredictable, value}
  function automatic logic [33:0] expand_imm_c(input logic [11:0] imm12, input logic cin);
    logic [7:0] b;
    logic [31:0] val;
    logic [63:0] dbl;
    logic bad;
    logic c;
    b = imm12[7:0];
    val = {24'h000000, b};
    bad = 1'b0;
    c = cin;
    dbl = 64'h0;
    if (imm12[11:10] == 2'b00) begin
      case (imm12[9:8])
        2'b00: val = {24'h000000, b};
        2'b01: val = {8'h00, b, 8'h00, b};
        2'b10: val = {b, 8'h00, b, 8'h00};
        default: val = {b, b, b, b};
      endcase
      bad = (imm12[9:8] != 2'b00) && (b == 8'h00);
    end else begin
      dbl = {24'h000000, 1'b1, imm12[6:0], 24'h000000, 1'b1, imm12[6:0]} >> imm12[11:7];
      val = dbl[31:0];
      c = val[31];
    end
    return {c, bad, val};
  endfunction

  function automatic logic [31:0] field_mask(input logic [4:0] msb, input logic [4:0] lsb);
    return (32'hFFFF_FFFF << lsb) & (32'hFFFF_FFFF >> (5'h1F - msb));
  endfunction

  function automatic logic reg_13_or_15(input logic [3:0] r);
    return (r == BFX_REG_SP) || (r == BFX_REG_PC);
  endfunction

  // Software-visible state
  logic [4:0] ctrl_q;
  logic [31:0] instr_q, rn_val_q, rm_val_q, rd_val_q, pc_val_q;
  logic [3:0] flags_in_q;
  logic [31:0] readdata_q, readdata_d;
  logic ack_q;
  bfx_state_t state_q, state_d;
  bfx_retire_t retire_q, retire_d;
  logic done_q, foreign_q, rsvd_q, skipped_q, breakpoint_op_mon_q, breakpoint_op_halt_q;

  // Bus decode
  wire logic access = avs_read | avs_write;
  wire logic hi_zero = (avs_address >> 8) == '0;
  wire logic [7:0] addr_lo = avs_address[7:0];
  wire logic commit = access & ack_q;
  wire logic wr_commit = commit & avs_write;
  wire logic sel_ctrl = hi_zero && addr_lo == BFX_OFF_CTRL;
  wire logic sel_instr = hi_zero && addr_lo == BFX_OFF_INSTR;
  wire logic sel_rn = hi_zero && addr_lo == BFX_OFF_RN_VAL;
  wire logic sel_rm = hi_zero && addr_lo == BFX_OFF_RM_VAL;
  wire logic sel_rd = hi_zero && addr_lo == BFX_OFF_RD_VAL;
  wire logic sel_pc = hi_zero && addr_lo == BFX_OFF_PC_VAL;
  wire logic sel_flags = hi_zero && addr_lo == BFX_OFF_FLAGS_IN;
  wire logic start = wr_commit && sel_ctrl && avs_byteenable[0] && avs_writedata[BFX_CTRL_START]
                     && state_q == BFX_ST_IDLE;
  wire logic [31:0] ctrl_word = merge_bytes({27'h0, ctrl_q}, avs_writedata, avs_byteenable);

  // Waitrequest is high for the first cycle of every access
  assign avs_waitrequest = access & ~ack_q;
  assign avs_readdata = readdata_q;
  assign retire = retire_q;

  // Instruction fields; the first halfword sits in the upper half of the word
  wire logic [15:0] hw1 = instr_q[31:16];
  wire logic [15:0] hw2 = instr_q[15:0];
  wire logic [3:0] rn_f = hw1[3:0];
  wire logic [3:0] rd_f = hw2[11:8];
  wire logic [3:0] rm_f = hw2[3:0];
  wire logic [4:0] lsb_f = {hw2[14:12], hw2[7:6]};
  wire logic [4:0] msb_f = hw2[4:0];
  wire logic [5:0] imm5_f = {1'b0, hw2[14:12], hw2[7:6]};
  wire logic [2:0] rdn16 = hw1[2:0];
  wire logic [2:0] rm16 = hw1[5:3];

  // Opcode recognition
  wire logic pat_breakpoint_op = hw1[15:8] == 8'hBE;
  wire logic pat_bic16 = hw1[15:6] == 10'h10E;
  wire logic pat_bic32 = hw1[15:5] == 11'h751;
  wire logic top_f = hw1[15:11] == 5'h1E;
  wire logic pat_bic_imm = top_f && hw1[9:5] == 5'h01 && !hw2[15];
  wire logic pat_bf = top_f && hw1[9:4] == 6'h36 && !hw2[15];
  wire logic pat_bl = top_f && hw2[15:14] == 2'h3 && hw2[12];
  wire logic pat_bcond = top_f && hw2[15:14] == 2'h2 && !hw2[12];
  wire logic cond_rsvd = pat_bcond && hw1[9:7] == 3'h7;

  bfx_op_t op;
  always_comb begin
    if (pat_breakpoint_op) begin
      op = BFX_OP_BREAKPOINT_OP;
    end else if (pat_bic16) begin
      op = BFX_OP_BIC_REG16;
    end else if (pat_bic32) begin
      op = BFX_OP_BIC_REG32;
    end else if (pat_bic_imm) begin
      op = BFX_OP_BIC_IMM;
    end else if (pat_bf) begin
      op = (rn_f == 4'hF) ? BFX_OP_FIELD_CLEAR : BFX_OP_FIELD_INSERT;
    end else if (pat_bl) begin
      op = BFX_OP_BL;
    end else if (cond_rsvd) begin
      op = BFX_OP_MISC_CTRL;
    end else begin
      op = BFX_OP_NONE;
    end
  end

  // Condition and block context
  wire logic cond_pass = ctrl_q[BFX_CTRL_COND_PASS];
  wire logic in_block = ctrl_q[BFX_CTRL_IN_BLOCK];
  wire logic last_in_block = ctrl_q[BFX_CTRL_LAST_IN_BLOCK];
  wire logic cin = flags_in_q[BFX_FLAG_C];

  // Field datapath
  wire logic [31:0] fmask = field_mask(msb_f, lsb_f);
  wire logic [31:0] fclear = rd_val_q & ~fmask;
  wire logic [31:0] finsert = fclear | ((rn_val_q << lsb_f) & fmask);
  wire logic range_ok = msb_f >= lsb_f;

  // Bit-clear datapath
  wire logic [33:0] imm_exp = expand_imm_c({hw1[10], hw2[14:12], hw2[7:0]}, cin);
  wire logic [31:0] bic_imm_res = rn_val_q & ~imm_exp[31:0];
  bfx_shift_t sh_t;
  logic [5:0] sh_n;
  always_comb begin
    sh_n = imm5_f;
    case (hw2[5:4])
      2'b00: sh_t = BFX_SH_LSL;
      2'b01: sh_t = BFX_SH_LSR;
      2'b10: sh_t = BFX_SH_ASR;
      default: sh_t = (imm5_f == 6'h00) ? BFX_SH_RRX : BFX_SH_ROR;
    endcase
    if (hw2[5:4] != 2'b00 && hw2[5:4] != 2'b11 && imm5_f == 6'h00) begin
      sh_n = 6'h20;
    end
    if (op == BFX_OP_BIC_REG16) begin
      sh_t = BFX_SH_LSL;
      sh_n = 6'h00;
    end
  end
  wire logic [32:0] shifted = shift_c(rm_val_q, sh_t, sh_n, cin);
  wire logic [31:0] bic_reg_res = rn_val_q & ~shifted[31:0];

  // Branch-with-link offset
  wire logic bl_s = hw1[10];
  wire logic bl_i1 = ~(hw2[13] ^ bl_s);
  wire logic bl_i2 = ~(hw2[11] ^ bl_s);
  wire logic [31:0] bl_off = {{7{bl_s}}, bl_s, bl_i1, bl_i2, hw1[9:0], hw2[10:0], 1'b0};

  function automatic logic [3:0] flags_of(input logic [31:0] r, input logic c, input logic [3:0] old);
    logic [3:0] f;
    f = old; // V kept
    f[BFX_FLAG_N] = r[31];
    f[BFX_FLAG_Z] = r == 32'h0000_0000;
    f[BFX_FLAG_C] = c;
    return f;
  endfunction

  // Execute one instruction into a retirement record
  always_comb begin
    retire_d = retire_q;
    retire_d.valid = 1'b0;
    retire_d.breakpoint_op_monitor = 1'b0;
    retire_d.breakpoint_op_halt = 1'b0;
    if (state_q == BFX_ST_EXEC) begin
      retire_d = '0;
      retire_d.valid = 1'b1;
      retire_d.flags = flags_in_q;
      case (op)
        BFX_OP_FIELD_CLEAR: begin
          retire_d.unpredictable = reg_13_or_15(rd_f) || !range_ok;
          retire_d.dest_num = rd_f;
          retire_d.dest_data = fclear;
          retire_d.wr_dest = cond_pass;
        end
        BFX_OP_FIELD_INSERT: begin
          retire_d.unpredictable = reg_13_or_15(rd_f) || rn_f == BFX_REG_SP || !range_ok;
          retire_d.dest_num = rd_f;
          retire_d.dest_data = finsert;
          retire_d.wr_dest = cond_pass;
        end
        BFX_OP_BIC_IMM: begin
          retire_d.unpredictable = reg_13_or_15(rd_f) || reg_13_or_15(rn_f) || imm_exp[32];
          retire_d.dest_num = rd_f;
          retire_d.dest_data = bic_imm_res;
          retire_d.wr_dest = cond_pass;
          retire_d.wr_flags = cond_pass && hw1[4];
          retire_d.flags = flags_of(bic_imm_res, imm_exp[33], flags_in_q);
        end
        BFX_OP_BIC_REG32: begin
          retire_d.unpredictable = reg_13_or_15(rd_f) || reg_13_or_15(rn_f) || reg_13_or_15(rm_f);
          retire_d.dest_num = rd_f;
          retire_d.dest_data = bic_reg_res;
          retire_d.wr_dest = cond_pass;
          retire_d.wr_flags = cond_pass && hw1[4];
          retire_d.flags = flags_of(bic_reg_res, shifted[32], flags_in_q);
        end
        BFX_OP_BIC_REG16: begin
          retire_d.dest_num = {1'b0, rdn16};
          retire_d.dest_data = bic_reg_res;
          retire_d.wr_dest = cond_pass;
          retire_d.wr_flags = cond_pass && !in_block;
          retire_d.flags = flags_of(bic_reg_res, shifted[32], flags_in_q);
        end
        BFX_OP_BREAKPOINT_OP: begin
          // Immediate byte deliberately unused
          retire_d.breakpoint_op_halt = ctrl_q[BFX_CTRL_HALT_SEL];
          retire_d.breakpoint_op_monitor = !ctrl_q[BFX_CTRL_HALT_SEL];
        end
        BFX_OP_BL: begin
          retire_d.unpredictable = in_block && !last_in_block;
          retire_d.dest_num = BFX_REG_LINK;
          retire_d.link_data = {pc_val_q[31:1], 1'b1};
          retire_d.target = pc_val_q + bl_off;
          retire_d.wr_link = cond_pass;
          retire_d.branch = cond_pass;
        end
        default: begin
        end
      endcase
      // Unpredictable encodings commit nothing, so the core state stays intact
      if (retire_d.unpredictable) begin
        retire_d.wr_dest = 1'b0;
        retire_d.wr_flags = 1'b0;
        retire_d.wr_link = 1'b0;
        retire_d.branch = 1'b0;
      end
      if (!cond_pass && op != BFX_OP_BREAKPOINT_OP) begin
        retire_d.wr_dest = 1'b0;
        retire_d.wr_flags = 1'b0;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      BFX_ST_IDLE: begin
        if (start) begin
          state_d = BFX_ST_EXEC;
        end
      end
      default: state_d = BFX_ST_IDLE;
    endcase
  end

  // Status word
  logic [31:0] status_v;
  always_comb begin
    status_v = 32'h0000_0000;
    status_v[BFX_ST_BUSY] = state_q == BFX_ST_EXEC;
    status_v[BFX_ST_DONE] = done_q;
    status_v[BFX_ST_UNPRED] = retire_q.unpredictable;
    status_v[BFX_ST_FOREIGN] = foreign_q;
    status_v[BFX_ST_RSVD_COND] = rsvd_q;
    status_v[BFX_ST_WR_DEST] = retire_q.wr_dest;
    status_v[BFX_ST_WR_FLAGS] = retire_q.wr_flags;
    status_v[BFX_ST_WR_LINK] = retire_q.wr_link;
    status_v[BFX_ST_BRANCH] = retire_q.branch;
    status_v[BFX_ST_BREAKPOINT_OP_MON] = breakpoint_op_mon_q;
    status_v[BFX_ST_BREAKPOINT_OP_HALT] = breakpoint_op_halt_q;
    status_v[BFX_ST_SKIPPED] = skipped_q;
    status_v[BFX_ST_DEST_LO +: 4] = retire_q.dest_num;
  end

  always_comb begin
    readdata_d = readdata_q;
    if (access && !ack_q) begin
      if (!avs_read) begin
        readdata_d = readdata_q;
      end else if (sel_ctrl) begin
        readdata_d = {27'h0, ctrl_q[4:1], 1'b0};
      end else if (sel_instr) begin
        readdata_d = instr_q;
      end else if (sel_rn) begin
        readdata_d = rn_val_q;
      end else if (sel_rm) begin
        readdata_d = rm_val_q;
      end else if (sel_rd) begin
        readdata_d = rd_val_q;
      end else if (sel_pc) begin
        readdata_d = pc_val_q;
      end else if (sel_flags) begin
        readdata_d = {28'h0, flags_in_q};
      end else if (hi_zero && addr_lo == BFX_OFF_STATUS) begin
        readdata_d = status_v;
      end else if (hi_zero && addr_lo == BFX_OFF_RESULT) begin
        readdata_d = retire_q.dest_data;
      end else if (hi_zero && addr_lo == BFX_OFF_FLAGS_OUT) begin
        readdata_d = {28'h0, retire_q.flags};
      end else if (hi_zero && addr_lo == BFX_OFF_LINK) begin
        readdata_d = retire_q.link_data;
      end else if (hi_zero && addr_lo == BFX_OFF_TARGET) begin
        readdata_d = retire_q.target;
      end else begin
        readdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      readdata_q <= BFX_WORD_RST;
      state_q <= BFX_ST_IDLE;
      retire_q <= '0;
    end else begin
      ack_q <= access & ~ack_q;
      readdata_q <= readdata_d;
      state_q <= state_d;
      retire_q <= retire_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= BFX_CTRL_RST;
      instr_q <= BFX_WORD_RST;
      rn_val_q <= BFX_WORD_RST;
      rm_val_q <= BFX_WORD_RST;
      rd_val_q <= BFX_WORD_RST;
      pc_val_q <= BFX_WORD_RST;
      flags_in_q <= BFX_FLAGS_RST;
    end else if (wr_commit) begin
      if (sel_ctrl) begin
        ctrl_q <= {ctrl_word[4:1], 1'b0};
      end
      if (sel_instr) begin
        instr_q <= merge_bytes(instr_q, avs_writedata, avs_byteenable);
      end
      if (sel_rn) begin
        rn_val_q <= merge_bytes(rn_val_q, avs_writedata, avs_byteenable);
      end
      if (sel_rm) begin
        rm_val_q <= merge_bytes(rm_val_q, avs_writedata, avs_byteenable);
      end
      if (sel_rd) begin
        rd_val_q <= merge_bytes(rd_val_q, avs_writedata, avs_byteenable);
      end
      if (sel_pc) begin
        pc_val_q <= merge_bytes(pc_val_q, avs_writedata, avs_byteenable);
      end
      if (sel_flags && avs_byteenable[0]) begin
        flags_in_q <= avs_writedata[3:0];
      end
    end
  end

  // Sticky summary of the last instruction, cleared when the next one starts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      foreign_q <= 1'b0;
      rsvd_q <= 1'b0;
      skipped_q <= 1'b0;
      breakpoint_op_mon_q <= 1'b0;
      breakpoint_op_halt_q <= 1'b0;
    end else if (start) begin
      done_q <= 1'b0;
      foreign_q <= 1'b0;
      rsvd_q <= 1'b0;
      skipped_q <= 1'b0;
      breakpoint_op_mon_q <= 1'b0;
      breakpoint_op_halt_q <= 1'b0;
    end else if (state_q == BFX_ST_EXEC) begin
      done_q <= 1'b1;
      foreign_q <= op == BFX_OP_NONE || op == BFX_OP_MISC_CTRL;
      rsvd_q <= op == BFX_OP_MISC_CTRL;
      skipped_q <= !cond_pass && op != BFX_OP_BREAKPOINT_OP && op != BFX_OP_NONE && op != BFX_OP_MISC_CTRL;
      breakpoint_op_mon_q <= retire_d.breakpoint_op_monitor;
      breakpoint_op_halt_q <= retire_d.breakpoint_op_halt;
    end
  end

endmodule

// ==== verilog/bfx_pkg.sv ====
// Shared constants and types for the bit-field, bit-clear, breakpoint and branch-with-link executor.
// Assumes a 32-bit data path and a byte-addressed Avalon-MM register window.
package bfx_pkg;

  // Register byte offsets
  localparam logic [7:0] BFX_OFF_CTRL = 8'h00;
  localparam logic [7:0] BFX_OFF_INSTR = 8'h04;
  localparam logic [7:0] BFX_OFF_RN_VAL = 8'h08;
  localparam logic [7:0] BFX_OFF_RM_VAL = 8'h0C;
  localparam logic [7:0] BFX_OFF_RD_VAL = 8'h10;
  localparam logic [7:0] BFX_OFF_PC_VAL = 8'h14;
  localparam logic [7:0] BFX_OFF_FLAGS_IN = 8'h18;
  localparam logic [7:0] BFX_OFF_STATUS = 8'h1C;
  localparam logic [7:0] BFX_OFF_RESULT = 8'h20;
  localparam logic [7:0] BFX_OFF_FLAGS_OUT = 8'h24;
  localparam logic [7:0] BFX_OFF_LINK = 8'h28;
  localparam logic [7:0] BFX_OFF_TARGET = 8'h2C;

  // Control register fields
  localparam int BFX_CTRL_START = 0;
  localparam int BFX_CTRL_COND_PASS = 1;
  localparam int BFX_CTRL_IN_BLOCK = 2;
  localparam int BFX_CTRL_LAST_IN_BLOCK = 3;
  localparam int BFX_CTRL_HALT_SEL = 4;
  localparam logic [4:0] BFX_CTRL_RST = 5'h00;
  localparam logic [31:0] BFX_WORD_RST = 32'h0000_0000;

  // Flag positions inside a 4-bit N,Z,C,V nibble
  localparam int BFX_FLAG_N = 3;
  localparam int BFX_FLAG_Z = 2;
  localparam int BFX_FLAG_C = 1;
  localparam int BFX_FLAG_V = 0;
  localparam logic [3:0] BFX_FLAGS_RST = 4'h0;

  // Status register fields
  localparam int BFX_ST_BUSY = 0;
  localparam int BFX_ST_DONE = 1;
  localparam int BFX_ST_UNPRED = 2;
  localparam int BFX_ST_FOREIGN = 3;
  localparam int BFX_ST_RSVD_COND = 4;
  localparam int BFX_ST_WR_DEST = 5;
  localparam int BFX_ST_WR_FLAGS = 6;
  localparam int BFX_ST_WR_LINK = 7;
  localparam int BFX_ST_BRANCH = 8;
  localparam int BFX_ST_BREAKPOINT_OP_MON = 9;
  localparam int BFX_ST_BREAKPOINT_OP_HALT = 10;
  localparam int BFX_ST_SKIPPED = 11;
  localparam int BFX_ST_DEST_LO = 12;

  // Register numbers with special meaning
  localparam logic [3:0] BFX_REG_SP = 4'hD;
  localparam logic [3:0] BFX_REG_PC = 4'hF;
  localparam logic [3:0] BFX_REG_LINK = 4'hE;

  typedef enum logic [3:0] {
    BFX_OP_NONE, BFX_OP_FIELD_CLEAR, BFX_OP_FIELD_INSERT, BFX_OP_BIC_IMM, BFX_OP_BIC_REG16,
    BFX_OP_BIC_REG32, BFX_OP_BREAKPOINT_OP, BFX_OP_BL, BFX_OP_MISC_CTRL
  } bfx_op_t;

  typedef enum logic [2:0] {BFX_SH_LSL, BFX_SH_LSR, BFX_SH_ASR, BFX_SH_ROR, BFX_SH_RRX} bfx_shift_t;

  // One retirement step towards the register file, flags, fetch and debug logic
  typedef struct packed {
    logic valid;
    logic unpredictable;
    logic wr_dest;
    logic [3:0] dest_num;
    logic [31:0] dest_data;
    logic wr_flags;
    logic [3:0] flags;
    logic wr_link;
    logic [31:0] link_data;
    logic branch;
    logic [31:0] target;
    logic breakpoint_op_monitor;
    logic breakpoint_op_halt;
  } bfx_retire_t;

endpackage
